// File: logic/wide_key_search_sequencer.sv
// host controller issuing 144-bit searches to a ternary search engine
//
// What this block does
// - cycle A drives command-valid high and search opcode 10 on command bits 1:0.
// - cycle A carries mask pair index on command bit 10 and bits 5:3.
// - cycle A bits 8:6 carry the SRAM address bits 23:21 used on hit.
// - cycle A data bus carries key bits 143:72, compared at even locations.
// - cycle A holds command bit 2 at zero.
// - cycle B keeps valid, repeats opcode, comparand pair index on bits 5:2.
// - cycle B bits 8:6 carry the result store register index.
// - cycle B data bus carries key bits 71:0, compared at odd locations.
// - all cascaded devices get the same table size and flag latency codes.
// - only the last device sets both last-driver bits; all others clear them. This block drives one shared pair, set from the config register.
// - 144-bit width across all octants is field value 0101010101010101.
`timescale 1ns/10ps
`include "wks_consts.svh"
module wide_key_search_sequencer
  import wks_pkg::*;
#(
  parameter int TIMEOUT = `RESULT_TIMEOUT,
  parameter logic [15:0] WIDTH_CFG = `WIDTH_CFG_144
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cmd_bus_t cmdBus,
  input result_bus_t resultPins,
  output logic [1:0] tableSizeCode,
  output logic [2:0] flagLatencyCode,
  output logic lastSramDriverBit,
  output logic lastFlagDriverBit,
  output logic [15:0] widthConfig
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [143:0] key;
    logic [3:0] maskPair;
    logic [2:0] sramHigh;
    logic [3:0] cmpIndex;
    logic [2:0] ssrIndex;
    logic reqPending;
    logic [1:0] table_size_code;
    logic [2:0] flag_latency_code;
    logic last_sram_driver_bit;
    logic last_flag_driver_bit;
    logic [15:0] searchCount;
    logic [15:0] hitCount;
    logic oddHitErr;
    logic [31:0] rdata;
  } top_t;
  top_t s_q, s_d;
  logic reqReady;
  logic issuedPulse;
  logic [23:0] lastAddr;
  logic lastHit;
  logic resultPulse;
  logic [7:0] pending;
  logic timeoutErr;
  logic apbAccess;
  logic addrOk;
  search_req_t req;
  assign apbAccess = psel && penable;
  assign pready = 1'b1;
  assign pslverr = apbAccess && !addrOk;
  assign prdata = s_q.rdata;
  // the device's codes are pins of this controller; software keeps them uniform
  assign tableSizeCode = s_q.table_size_code;
  assign flagLatencyCode = s_q.flag_latency_code;
  assign lastSramDriverBit = s_q.last_sram_driver_bit;
  assign lastFlagDriverBit = s_q.last_flag_driver_bit;
  assign widthConfig = WIDTH_CFG;
  assign req.maskPair = s_q.maskPair;
  assign req.sramHigh = s_q.sramHigh;
  assign req.cmpIndex = s_q.cmpIndex;
  assign req.ssrIndex = s_q.ssrIndex;
  assign req.key = s_q.key;
  // ************************************************************
  // command issue and result capture
  // ************************************************************
  search_issuer u_issuer (
    .clk(clk),
    .reset(reset),
    .reqValid(s_q.reqPending),
    .reqReady(reqReady),
    .req(req),
    .cmdBus(cmdBus),
    .issuedPulse(issuedPulse)
  );
  result_catcher #(.TIMEOUT(TIMEOUT)) u_catcher (
    .clk(clk),
    .reset(reset),
    .issuedPulse(issuedPulse),
    .flagLatency(s_q.flag_latency_code),
    .resultPins(resultPins),
    .lastAddr(lastAddr),
    .lastHit(lastHit),
    .resultPulse(resultPulse),
    .pending(pending),
    .timeoutErr(timeoutErr)
  );
  // ************************************************************
  // register file
  // ************************************************************
  always_comb begin
    addrOk = 1'b1;
    if (paddr == `REG_CTRL) begin
      addrOk = 1'b1;
    end else if (paddr == `REG_KEY_HI0 || paddr == `REG_KEY_HI1 || paddr == `REG_KEY_HI2) begin
      addrOk = 1'b1;
    end else if (paddr == `REG_KEY_LO0 || paddr == `REG_KEY_LO1 || paddr == `REG_KEY_LO2) begin
      addrOk = 1'b1;
    end else if (paddr == `REG_STATUS || paddr == `REG_RESULT || paddr == `REG_CONFIG) begin
      addrOk = 1'b1;
    end else begin
      addrOk = 1'b0;
    end
  end
  always_comb begin
    s_d = s_q;
    // one request at a time from software; the issuer pipelines back to back
    if (s_q.reqPending && reqReady) begin
      s_d.reqPending = 1'b0;
    end
    if (issuedPulse) begin
      s_d.searchCount = s_q.searchCount + 16'h0001;
    end
    if (resultPulse && lastHit) begin
      s_d.hitCount = s_q.hitCount + 16'h0001;
      // a 144-bit table must answer on an even word
      if (lastAddr[0]) begin
        s_d.oddHitErr = 1'b1;
      end
    end
    if (apbAccess && pwrite) begin
      if (paddr == `REG_CTRL) begin
        if (pwdata[`CTRL_GO_BIT]) begin
          s_d.reqPending = 1'b1;
        end
        s_d.maskPair = pwdata[`CTRL_MASK_LSB +: 4];
        s_d.sramHigh = pwdata[`CTRL_SRAMHI_LSB +: 3];
        s_d.cmpIndex = pwdata[`CTRL_CMPIDX_LSB +: 4];
        s_d.ssrIndex = pwdata[`CTRL_SSRIDX_LSB +: 3];
      end else if (paddr == `REG_KEY_HI0) begin
        s_d.key[103:72] = pwdata;
      end else if (paddr == `REG_KEY_HI1) begin
        s_d.key[135:104] = pwdata;
      end else if (paddr == `REG_KEY_HI2) begin
        s_d.key[143:136] = pwdata[7:0];
      end else if (paddr == `REG_KEY_LO0) begin
        s_d.key[31:0] = pwdata;
      end else if (paddr == `REG_KEY_LO1) begin
        s_d.key[63:32] = pwdata;
      end else if (paddr == `REG_KEY_LO2) begin
        s_d.key[71:64] = pwdata[7:0];
      end else if (paddr == `REG_STATUS) begin
        // write one to clear; a new odd hit in the same cycle wins
        if (pwdata[2] && !(resultPulse && lastHit && lastAddr[0])) begin
          s_d.oddHitErr = 1'b0;
        end
      end else if (paddr == `REG_CONFIG) begin
        s_d.table_size_code = pwdata[`CFG_TABLE_SIZE_CODE_LSB +: 2];
        s_d.flag_latency_code = pwdata[`CFG_FLAG_LATENCY_CODE_LSB +: 3];
        s_d.last_sram_driver_bit = pwdata[`CFG_LAST_SRAM_DRIVER_BIT_BIT];
        s_d.last_flag_driver_bit = pwdata[`CFG_LAST_FLAG_DRIVER_BIT_BIT];
      end
    end
    s_d.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == `REG_CTRL) begin
        s_d.rdata = {12'h000, 1'b0, s_q.ssrIndex, s_q.cmpIndex, 1'b0, s_q.sramHigh, s_q.maskPair,
                     3'b000, s_q.reqPending};
      end else if (paddr == `REG_KEY_HI0) begin
        s_d.rdata = s_q.key[103:72];
      end else if (paddr == `REG_KEY_HI1) begin
        s_d.rdata = s_q.key[135:104];
      end else if (paddr == `REG_KEY_HI2) begin
        s_d.rdata = {24'h000000, s_q.key[143:136]};
      end else if (paddr == `REG_KEY_LO0) begin
        s_d.rdata = s_q.key[31:0];
      end else if (paddr == `REG_KEY_LO1) begin
        s_d.rdata = s_q.key[63:32];
      end else if (paddr == `REG_KEY_LO2) begin
        s_d.rdata = {24'h000000, s_q.key[71:64]};
      end else if (paddr == `REG_STATUS) begin
        // a search still on the command pins counts as pending, else software sees a gap
        s_d.rdata = {s_q.hitCount[7:0], pending, 13'h0000, s_q.oddHitErr, timeoutErr,
                     s_q.reqPending || cmdBus.commandValid};
      end else if (paddr == `REG_RESULT) begin
        s_d.rdata = {7'h00, lastHit, lastAddr};
      end else if (paddr == `REG_CONFIG) begin
        s_d.rdata = {s_q.searchCount, 6'h00, s_q.last_flag_driver_bit, s_q.last_sram_driver_bit, 1'b0, s_q.flag_latency_code, 2'b00, s_q.table_size_code};
      end
    end
  end
  // read data is registered at the setup edge, so it stands through the access phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : wide_key_search_sequencer

// File: common/wks_consts.svh
// constants for the wide key search host controller
`ifndef WKS_CONSTS_SVH
`define WKS_CONSTS_SVH
// ************************************************************
// register offsets (APB byte addresses)
// ************************************************************
`define REG_CTRL 12'h000
`define REG_KEY_HI0 12'h004
`define REG_KEY_HI1 12'h008
`define REG_KEY_HI2 12'h00C
`define REG_KEY_LO0 12'h010
`define REG_KEY_LO1 12'h014
`define REG_KEY_LO2 12'h018
`define REG_STATUS 12'h01C
`define REG_RESULT 12'h020
`define REG_CONFIG 12'h024
// ************************************************************
// field positions
// ************************************************************
`define CTRL_GO_BIT 0
`define CTRL_MASK_LSB 4
`define CTRL_SRAMHI_LSB 8
`define CTRL_CMPIDX_LSB 12
`define CTRL_SSRIDX_LSB 16
`define CFG_TABLE_SIZE_CODE_LSB 0
`define CFG_FLAG_LATENCY_CODE_LSB 4
`define CFG_LAST_SRAM_DRIVER_BIT_BIT 8
`define CFG_LAST_FLAG_DRIVER_BIT_BIT 9
// ************************************************************
// device encodings and timing
// ************************************************************
`define OP_SEARCH 2'b10
`define WIDTH_CFG_144 16'h5555
`define TABLE_SIZE_CODE_SINGLE 2'b00
`define TABLE_SIZE_CODE_EIGHT 2'b01
`define TABLE_SIZE_CODE_FULL 2'b10
`define LAT_SINGLE 4
`define LAT_EIGHT 5
`define LAT_FULL 6
`define CFG_RESET 32'h0000_0000
`define RESULT_TIMEOUT 64
`endif

// File: common/wks_pkg.sv
// types for the wide key search host controller
package wks_pkg;
  typedef struct packed {
    logic commandValid;
    logic [10:0] command;
    logic [71:0] dataBus;
  } cmd_bus_t;
  typedef struct packed {
    logic [23:0] sramAddressOut;
    logic searchValidStrobe;
    logic searchHitStrobe;
  } result_bus_t;
  typedef struct packed {
    logic [3:0] maskPair;
    logic [2:0] sramHigh;
    logic [3:0] cmpIndex;
    logic [2:0] ssrIndex;
    logic [143:0] key;
  } search_req_t;
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    CYC_A = 3'b010,
    CYC_B = 3'b100
  } issue_state_t;
endpackage : wks_pkg

// File: logic/search_issuer.sv
// drives the two-cycle search command onto the device pins
`timescale 1ns/10ps
module search_issuer
  import wks_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic reqValid,
  output logic reqReady,
  input search_req_t req,
  output cmd_bus_t cmdBus,
  output logic issuedPulse
);
`include "wks_consts.svh"
  typedef struct packed {
    issue_state_t st;
    search_req_t hold;
    cmd_bus_t bus;
    logic issued;
  } iss_t;
  iss_t s_q, s_d;
  // a new request is taken in the second command cycle so searches run back to back
  assign reqReady = (s_q.st == IDLE) || (s_q.st == CYC_B);
  assign cmdBus = s_q.bus;
  assign issuedPulse = s_q.issued;
  always_comb begin
    s_d = s_q;
    s_d.issued = 1'b0;
    s_d.bus.commandValid = 1'b0;
    s_d.bus.command = 11'h000;
    s_d.bus.dataBus = 72'h0;
    case (s_q.st)
      IDLE, CYC_B: begin
        if (reqValid) begin
          s_d.hold = req;
          s_d.st = CYC_A;
          s_d.bus.commandValid = 1'b1;
          s_d.bus.command[1:0] = `OP_SEARCH;
          s_d.bus.command[10] = req.maskPair[3];
          s_d.bus.command[5:3] = req.maskPair[2:0];
          s_d.bus.command[8:6] = req.sramHigh;
          s_d.bus.command[2] = 1'b0;
          s_d.bus.dataBus = req.key[143:72];
        end else begin
          s_d.st = IDLE;
        end
      end
      CYC_A: begin
        s_d.st = CYC_B;
        s_d.issued = 1'b1;
        s_d.bus.commandValid = 1'b1;
        s_d.bus.command[1:0] = `OP_SEARCH;
        s_d.bus.command[5:2] = s_q.hold.cmpIndex;
        s_d.bus.command[8:6] = s_q.hold.ssrIndex;
        s_d.bus.dataBus = s_q.hold.key[71:0];
      end
      default: s_d.st = IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '{st: IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
endmodule : search_issuer

// File: logic/result_catcher.sv
// waits for the strobes of each issued search and captures the answer
`timescale 1ns/10ps
`include "wks_consts.svh"
module result_catcher
  import wks_pkg::*;
#(
  parameter int TIMEOUT = `RESULT_TIMEOUT
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic issuedPulse,
  input wire logic [2:0] flagLatency,
  input result_bus_t resultPins,
  output logic [23:0] lastAddr,
  output logic lastHit,
  output logic resultPulse,
  output logic [7:0] pending,
  output logic timeoutErr
);
  // ************************************************************
  // result capture
  // ************************************************************
  // the device runs on this clock, so its pins are read directly
  typedef struct packed {
    logic [7:0][23:0] addrHist;
    logic [23:0] addr;
    logic hit;
    logic pulse;
    logic [7:0] outstanding;
    logic [7:0] waitCnt;
    logic tout;
  } rc_t;
  rc_t s_q, s_d;
  logic strobeSeen;
  logic [7:0][23:0] addrNow;
  assign lastAddr = s_q.addr;
  assign lastHit = s_q.hit;
  assign resultPulse = s_q.pulse;
  assign pending = s_q.outstanding;
  assign timeoutErr = s_q.tout;
  always_comb begin
    s_d = s_q;
    // address stands only in the access cycle; strobes trail it by the flag latency
    addrNow = {s_q.addrHist[6:0], resultPins.sramAddressOut};
    s_d.addrHist = addrNow;
    s_d.pulse = 1'b0;
    // one strobe per search: the device answers every search, hit or miss
    strobeSeen = resultPins.searchValidStrobe;
    if (strobeSeen) begin
      s_d.addr = addrNow[flagLatency];
      s_d.hit = resultPins.searchHitStrobe;
      s_d.pulse = 1'b1;
    end
    if (issuedPulse && !strobeSeen) begin
      s_d.outstanding = s_q.outstanding + 8'h01;
    end else if (!issuedPulse && strobeSeen && s_q.outstanding != 8'h00) begin
      s_d.outstanding = s_q.outstanding - 8'h01;
    end
    if (s_q.outstanding == 8'h00 || strobeSeen) begin
      s_d.waitCnt = 8'h00;
    end else if (s_q.waitCnt == 8'(TIMEOUT)) begin
      s_d.tout = 1'b1;
    end else begin
      s_d.waitCnt = s_q.waitCnt + 8'h01;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : result_catcher

// File: tb/wks_checker.sv
// pin-level assertions for the wide key search host controller
`timescale 1ns/10ps
module wks_checker
  import wks_pkg::*;
#(
  parameter int TIMEOUT = 64,
  parameter logic [15:0] WIDTH_CFG = 16'h5555
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input cmd_bus_t cmdBus,
  input result_bus_t resultPins,
  input wire logic [1:0] tableSizeCode,
  input wire logic [2:0] flagLatencyCode,
  input wire logic lastSramDriverBit,
  input wire logic lastFlagDriverBit,
  input wire logic [15:0] widthConfig
);
  // ************************************************************
  // helper state: which command cycle, last control word
  // ************************************************************
  logic phaseQ;
  logic [31:0] ctrlQ;
  wire logic ctrlWr = psel && penable && pwrite && paddr == 12'h000;
  wire logic cfgWr = psel && penable && pwrite && paddr == 12'h024;
  wire logic aCyc = cmdBus.commandValid && !phaseQ;
  wire logic bCyc = cmdBus.commandValid && phaseQ;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phaseQ <= 1'b0;
      ctrlQ <= 32'h0000_0000;
    end else begin
      phaseQ <= cmdBus.commandValid && !phaseQ;
      if (ctrlWr) begin
        ctrlQ <= pwdata;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_cyc_a_code: assert property (aCyc |-> cmdBus.command[2:0] == 3'b010)
    else $error("first command cycle has wrong opcode or bit 2");
  a_cyc_b_follows: assert property (aCyc |=> cmdBus.commandValid && cmdBus.command[1:0] == 2'b10)
    else $error("second command cycle missing");
  a_mask_pair: assert property (aCyc |-> {cmdBus.command[10], cmdBus.command[5:3]} == ctrlQ[7:4])
    else $error("mask pair index wrong");
  a_sram_high: assert property (aCyc |-> cmdBus.command[8:6] == ctrlQ[10:8])
    else $error("sram high bits wrong");
  a_cmp_index: assert property (bCyc |-> cmdBus.command[5:2] == $past(ctrlQ[15:12]))
    else $error("comparand index wrong");
  a_ssr_index: assert property (bCyc |-> cmdBus.command[8:6] == $past(ctrlQ[18:16]))
    else $error("result store index wrong");
  a_go_issues: assert property (ctrlWr && pwdata[0] && !cmdBus.commandValid |-> ##[1:3] aCyc)
    else $error("search not issued after go");
  a_cfg_codes: assert property (cfgWr |=> tableSizeCode == $past(pwdata[1:0])
    && flagLatencyCode == $past(pwdata[6:4])) else $error("table size or flag latency code wrong");
  a_last_bits: assert property (cfgWr |=> {lastFlagDriverBit, lastSramDriverBit} == $past(pwdata[9:8]))
    else $error("last driver bits wrong");
  a_width_code: assert property (widthConfig == 16'h5555)
    else $error("width configuration not 144-bit");
endmodule : wks_checker

bind wide_key_search_sequencer wks_checker #(.TIMEOUT(TIMEOUT), .WIDTH_CFG(WIDTH_CFG)) chk (.clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmdBus, .resultPins, .tableSizeCode,
  .flagLatencyCode, .lastSramDriverBit, .lastFlagDriverBit, .widthConfig);

// File: tb/wks_device_model.sv
// behavioural search engine answering the two-cycle search command
`timescale 1ns/10ps
module wks_device_model
  import wks_pkg::*;
(
  input wire logic clk,
  input cmd_bus_t cmdBus,
  input wire logic [1:0] tableSizeCode,
  input wire logic [2:0] flagLatencyCode,
  input wire logic lastSramDriverBit,
  input wire logic lastFlagDriverBit,
  output result_bus_t resultPins
);
  // ************************************************************
  // table, command capture and result pipeline
  // ************************************************************
  logic [143:0] ent [4];
  logic [143:0] cmpReg [16];
  logic [24:0] ssrReg [8];
  logic [71:0] hiQ;
  logic [71:0] mk;
  logic [143:0] key;
  logic [3:0] maskQ;
  logic [2:0] sramQ;
  logic [20:0] loc;
  logic inB;
  logic hit;
  logic [15:0] aV;
  logic [15:0] sV;
  logic [15:0] hP;
  logic [23:0] aP [16];
  logic [23:0] lastA;
  int lat;
  initial begin
    for (int i = 0; i < 3; i++) ent[i] = {36{4'(i + 1)}};
    ent[3] = ent[0];
    inB = 1'b0;
    aV = 16'h0000;
    sV = 16'h0000;
    hP = 16'h0000;
    lastA = 24'h000000;
  end
  always @(posedge clk) begin
    aV <= aV >> 1;
    sV <= sV >> 1;
    hP <= hP >> 1;
    for (int i = 0; i < 15; i++) aP[i] <= aP[i + 1];
    if (aV[0]) lastA <= aP[0];
    inB <= 1'b0;
    if (cmdBus.commandValid && !inB && cmdBus.command[2:0] == 3'b010) begin
      hiQ <= cmdBus.dataBus;
      maskQ <= {cmdBus.command[10], cmdBus.command[5:3]};
      sramQ <= cmdBus.command[8:6];
      inB <= 1'b1;
    end else if (inB && cmdBus.commandValid && cmdBus.command[1:0] == 2'b10) begin
      key = {hiQ, cmdBus.dataBus};
      // pair 0 compares every bit, other pairs ignore the low byte of each half
      mk = (maskQ == 4'h0) ? {72{1'b1}} : {{64{1'b1}}, 8'h00};
      hit = 1'b0;
      loc = 21'h000000;
      for (int i = 3; i >= 0; i--) begin
        if (((ent[i] ^ key) & {mk, mk}) == 144'h0) begin
          hit = 1'b1;
          loc = 21'(2 * i);
        end
      end
      lat = (tableSizeCode == 2'b00) ? 4 : ((tableSizeCode == 2'b01) ? 5 : 6);
      aV[lat - 1] <= 1'b1;
      aP[lat - 1] <= {sramQ, loc};
      sV[lat - 1 + flagLatencyCode] <= 1'b1;
      hP[lat - 1 + flagLatencyCode] <= hit;
      cmpReg[cmdBus.command[5:2]] <= key;
      ssrReg[cmdBus.command[8:6]] <= {hit, sramQ, loc};
    end
  end
  // address is only valid in the access cycle; otherwise it shows garbage
  assign resultPins.sramAddressOut = (aV[0] && lastSramDriverBit) ? aP[0] : ~lastA;
  assign resultPins.searchValidStrobe = sV[0] && lastFlagDriverBit;
  assign resultPins.searchHitStrobe = sV[0] && hP[0] && lastFlagDriverBit;
endmodule : wks_device_model

// File: tb/test_wide_key_search_sequencer.sv
// self-checking testbench for the wide key search host controller
`timescale 1ns/10ps
module test_wide_key_search_sequencer;
  import wks_pkg::*;
  // ************************************************************
  // signals, design and device
  // ************************************************************
  logic clk, reset, psel, penable, pwrite, pready, pslverr, errSeen;
  logic lastSramDriverBit, lastFlagDriverBit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] tableSizeCode;
  logic [2:0] flagLatencyCode;
  logic [15:0] widthConfig;
  logic [2:0] hl [3] = '{3'h0, 3'h2, 3'h7};
  logic [143:0] flip = {64'h0, 8'hFF, 64'h0, 8'hFF};
  cmd_bus_t cmdBus;
  result_bus_t resultPins;
  int n_errors = 0;
  int comparisons = 0;
  int hits = 0;
  wide_key_search_sequencer uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmdBus(cmdBus),
    .resultPins(resultPins), .tableSizeCode(tableSizeCode), .flagLatencyCode(flagLatencyCode),
    .lastSramDriverBit(lastSramDriverBit), .lastFlagDriverBit(lastFlagDriverBit), .widthConfig(widthConfig));
  wks_device_model dev (.clk(clk), .cmdBus(cmdBus), .tableSizeCode(tableSizeCode),
    .flagLatencyCode(flagLatencyCode), .lastSramDriverBit(lastSramDriverBit),
    .lastFlagDriverBit(lastFlagDriverBit), .resultPins(resultPins));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ************************************************************
  // bus and check tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    errSeen = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic load_key(input logic [143:0] k);
    apb(1'b1, 12'h004, k[103:72]);
    apb(1'b1, 12'h008, k[135:104]);
    apb(1'b1, 12'h00C, {24'h000000, k[143:136]});
    apb(1'b1, 12'h010, k[31:0]);
    apb(1'b1, 12'h014, k[63:32]);
    apb(1'b1, 12'h018, {24'h000000, k[71:64]});
  endtask : load_key
  task automatic go(input logic [3:0] mp, input logic [2:0] hi);
    apb(1'b1, 12'h000, {13'h0000, 3'h5, 4'h9, 1'b0, hi, mp, 3'h0, 1'b1});
  endtask : go
  task automatic finish_search(input logic [2:0] hi, input int idx);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, 12'h01C, 32'h0000_0000);
      if (rd[23:16] === 8'h00 && rd[0] === 1'b0) break;
    end
    apb(1'b0, 12'h020, 32'h0000_0000);
    if (idx >= 0) begin
      hits++;
      check(rd, {7'h00, 1'b1, hi, 21'(2 * idx)});
    end else begin
      check(rd[24], 1'b0);
    end
  endtask : finish_search
  task automatic end_of_test;
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, 12'h024, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h030, 32'h0000_0000);
    check({errSeen, rd}, {1'b1, 32'h0000_0000});
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 12'h024, {22'h000000, 2'b11, 1'b0, hl[k], 2'b00, 2'(k)});
      @(negedge clk);
      check({lastFlagDriverBit, lastSramDriverBit, flagLatencyCode, tableSizeCode}, {2'b11, hl[k], 2'(k)});
      load_key({36{4'h1}});
      go(4'h0, 3'h5);
      finish_search(3'h5, 0);
      load_key({36{4'h2}} ^ flip);
      go(4'h9, 3'h2);
      finish_search(3'h2, 1);
      go(4'h0, 3'h3);
      finish_search(3'h3, -1);
    end
    load_key({36{4'h3}});
    go(4'h0, 3'h1);
    go(4'h0, 3'h6);
    hits++;
    finish_search(3'h6, 2);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    check({rd[31:24], rd[1]}, {8'(hits), 1'b0});
    apb(1'b0, 12'h024, 32'h0000_0000);
    check(rd[31:16], 16'h000B);
    end_of_test();
  end
endmodule : test_wide_key_search_sequencer
